// file: sram_pkg.sv
/*
 * shared constants and types for the synchronous sram port
 * assumes a single 125 MHz clock and a synchronous active-high reset
 */
package sram_pkg;

    localparam int LANE_BITS  = 9;
    localparam int LANES      = 4;
    localparam int DATA_BITS  = LANE_BITS * LANES;
    // array depth is kept small here; the full part holds 1M words of 36 bits
    localparam int ADDR_BITS  = 8;
    localparam int DEPTH      = 256;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_PTR   = 3;

    // pipelined read data leaves two edges after the command, flow-through one
    localparam int PIPE_LAT   = 2;
    localparam int FLOW_LAT   = 1;

    localparam logic [1:0] BURST_SEED_RESET = 2'h0;

    typedef enum logic [1:0] {
        SRAM_OP_IDLE,
        SRAM_OP_READ,
        SRAM_OP_WRITE
    } sram_op_t;

    typedef enum {
        SRAM_PWR_AWAKE,
        SRAM_PWR_SLEEP
    } sram_pwr_t;

endpackage

// file: sram_fifo.sv
/*
 * small flop-based fifo with valid/ready on both sides
 * assumes both sides on mclk; reset is synchronous, active high
 */
`timescale 1ns/1ps
module sram_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 8,
    parameter int PTR   = 3
) (
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PTR-1:0]   wr_reg;
    logic [PTR-1:0]   rd_reg;
    logic [PTR:0]     cnt_reg;
    logic             push;
    logic             pop;

    // full only once every entry holds a word; the count is one bit wider than the pointers
    assign in_ready  = (cnt_reg < (PTR+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem_reg[rd_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge mclk) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + {{PTR{1'b0}}, push} - {{PTR{1'b0}}, pop};
        end
    end

endmodule

// file: sram_port.sv
/*
 * synchronous sram port with no bus turnaround: pipelined or flow-through
 * assumes a host controller on mclk; data pins are split into in/out/enable
 */
`timescale 1ns/1ps
module sram_port (
    input  wire logic                                 mclk,
    input  wire logic                                 reset,
    input  wire logic                                 clock_gate_n,
    input  wire logic [sram_pkg::ADDR_BITS-1:0]       addr,
    input  wire logic                                 burst_seed_bit0,
    input  wire logic                                 burst_seed_bit1,
    input  wire logic                                 advance_load,
    input  wire logic                                 write_n,
    input  wire logic                                 lane_a_write_n,
    input  wire logic                                 lane_b_write_n,
    input  wire logic                                 lane_c_write_n,
    input  wire logic                                 lane_d_write_n,
    input  wire logic                                 chip_sel_one_n,
    input  wire logic                                 chip_sel_two,
    input  wire logic                                 chip_sel_three_n,
    input  wire logic                                 mode_select_pin,
    input  wire logic                                 burst_order_select,
    input  wire logic                                 output_enable_n,
    input  wire logic                                 sleep_request,
    input  wire logic [sram_pkg::DATA_BITS-1:0]       dq_in,
    output logic      [sram_pkg::DATA_BITS-1:0]       dq_out,
    output logic                                      dq_oe,
    output logic                                      sleeping,
    output logic                                      write_stall
);

    // ************************************************
    // asynchronous pins: three-flop sync, agree on 2nd/3rd
    // ************************************************
    logic [2:0] oe_sync_reg;
    logic [2:0] zz_sync_reg;
    logic       oe_n_reg;
    logic       zz_reg;

    always_ff @(posedge mclk) begin
        if (reset) begin
            oe_sync_reg <= 3'h7;
            zz_sync_reg <= 3'h0;
        end else begin
            oe_sync_reg <= {oe_sync_reg[1:0], output_enable_n};
            zz_sync_reg <= {zz_sync_reg[1:0], sleep_request};
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            oe_n_reg <= 1'b1;
            zz_reg   <= 1'b0;
        end else begin
            if (oe_sync_reg[1] == oe_sync_reg[2]) begin
                oe_n_reg <= oe_sync_reg[2];
            end
            if (zz_sync_reg[1] == zz_sync_reg[2]) begin
                zz_reg <= zz_sync_reg[2];
            end
        end
    end

    // ************************************************
    // sleep state
    // ************************************************
    sram_pkg::sram_pwr_t pwr_reg;

    always_ff @(posedge mclk) begin
        if (reset) begin
            pwr_reg <= sram_pkg::SRAM_PWR_AWAKE;
        end else begin
            case (pwr_reg)
                sram_pkg::SRAM_PWR_AWAKE: begin
                    if (zz_reg) begin
                        pwr_reg <= sram_pkg::SRAM_PWR_SLEEP;
                    end
                end
                sram_pkg::SRAM_PWR_SLEEP: begin
                    if (!zz_reg) begin
                        pwr_reg <= sram_pkg::SRAM_PWR_AWAKE;
                    end
                end
                default: begin
                    pwr_reg <= sram_pkg::SRAM_PWR_AWAKE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            sleeping <= 1'b0;
        end else begin
            sleeping <= (pwr_reg == sram_pkg::SRAM_PWR_SLEEP);
        end
    end

    // ************************************************
    // command decode
    // ************************************************
    logic       adv_en;
    logic       selected;
    logic       begin_read;
    logic       begin_write;
    logic       cont_burst;
    logic [3:0] lane_n;
    logic       fifo_in_ready;

    // sleep also blocks the clock; a stalled fifo would drop a write
    assign adv_en      = !clock_gate_n && (pwr_reg == sram_pkg::SRAM_PWR_AWAKE)
                         && fifo_in_ready;
    assign selected    = !chip_sel_one_n && chip_sel_two && !chip_sel_three_n;
    assign begin_read  = adv_en && !advance_load && selected && write_n;
    assign begin_write = adv_en && !advance_load && selected && !write_n;
    assign cont_burst  = adv_en && advance_load;
    assign lane_n      = {lane_d_write_n, lane_c_write_n, lane_b_write_n, lane_a_write_n};

    // ************************************************
    // burst address counter
    // ************************************************
    logic [sram_pkg::ADDR_BITS-1:0] base_reg;
    logic [1:0]                     seed_reg;
    logic [1:0]                     step_reg;
    logic                           burst_rd_reg;
    logic                           burst_wr_reg;
    logic                           burst_on_reg;
    logic [1:0]                     low_bits;
    logic [1:0]                     step_next;
    logic [sram_pkg::ADDR_BITS-1:0] cur_addr;

    assign step_next = step_reg + 2'h1;
    // linear when select is low, interleaved otherwise
    assign low_bits  = burst_order_select ? (seed_reg ^ step_next)
                                          : (seed_reg + step_next);
    assign cur_addr  = begin_read || begin_write
                       ? {addr[sram_pkg::ADDR_BITS-1:2], burst_seed_bit1, burst_seed_bit0}
                       : {base_reg[sram_pkg::ADDR_BITS-1:2], low_bits};

    always_ff @(posedge mclk) begin
        if (reset) begin
            base_reg     <= '0;
            seed_reg     <= sram_pkg::BURST_SEED_RESET;
            step_reg     <= 2'h0;
            burst_rd_reg <= 1'b0;
            burst_wr_reg <= 1'b0;
            burst_on_reg <= 1'b0;
        end else if (adv_en) begin
            if (begin_read || begin_write) begin
                base_reg     <= addr;
                seed_reg     <= {burst_seed_bit1, burst_seed_bit0};
                step_reg     <= 2'h0;
                burst_rd_reg <= begin_read;
                burst_wr_reg <= begin_write;
                burst_on_reg <= 1'b1;
            end else if (cont_burst) begin
                step_reg <= step_next;
            end else begin
                burst_on_reg <= 1'b0;
            end
        end
    end

    logic do_read;
    logic do_write;

    assign do_read  = begin_read || (cont_burst && burst_on_reg && burst_rd_reg);
    assign do_write = begin_write || (cont_burst && burst_on_reg && burst_wr_reg);

    // ************************************************
    // late write pipeline: command stages then data
    // ************************************************
    logic [sram_pkg::PIPE_LAT-1:0]  wr_vld_reg;
    logic [sram_pkg::ADDR_BITS-1:0] wr_addr_reg [sram_pkg::PIPE_LAT];
    logic [3:0]                     wr_lane_reg [sram_pkg::PIPE_LAT];
    logic                           wr_due;
    logic [sram_pkg::ADDR_BITS-1:0] wr_due_addr;
    logic [3:0]                     wr_due_lane;

    always_ff @(posedge mclk) begin
        if (reset) begin
            wr_vld_reg <= '0;
        end else if (adv_en) begin
            wr_vld_reg <= {wr_vld_reg[0], do_write};
        end
    end

    always_ff @(posedge mclk) begin
        if (adv_en) begin
            wr_addr_reg[0] <= cur_addr;
            wr_lane_reg[0] <= lane_n;
            wr_addr_reg[1] <= wr_addr_reg[0];
            wr_lane_reg[1] <= wr_lane_reg[0];
        end
    end

    // flow-through takes data one edge after command, pipelined two
    assign wr_due      = mode_select_pin ? wr_vld_reg[1] : wr_vld_reg[0];
    assign wr_due_addr = mode_select_pin ? wr_addr_reg[1] : wr_addr_reg[0];
    assign wr_due_lane = mode_select_pin ? wr_lane_reg[1] : wr_lane_reg[0];

    // ************************************************
    // write fifo and self-timed array commit
    // ************************************************
    localparam int FW = sram_pkg::ADDR_BITS + 4 + sram_pkg::DATA_BITS;

    logic          fifo_out_valid;
    logic [FW-1:0] fifo_out_data;
    logic          commit_en;

    sram_fifo #(
        .WIDTH (FW),
        .DEPTH (sram_pkg::FIFO_DEPTH),
        .PTR   (sram_pkg::FIFO_PTR)
    ) u_wfifo (
        .mclk      (mclk),
        .reset     (reset),
        .in_valid  (wr_due && adv_en),
        .in_ready  (fifo_in_ready),
        .in_data   ({wr_due_addr, wr_due_lane, dq_in}),
        .out_valid (fifo_out_valid),
        .out_ready (commit_en),
        .out_data  (fifo_out_data)
    );

    // the array stops committing in sleep, but writes stop too, so the fifo never holds more than one word
    assign commit_en = (pwr_reg == sram_pkg::SRAM_PWR_AWAKE);

    always_ff @(posedge mclk) begin
        if (reset) begin
            write_stall <= 1'b0;
        end else begin
            write_stall <= !fifo_in_ready;
        end
    end

    logic [sram_pkg::DATA_BITS-1:0] array_word;
    logic [sram_pkg::ADDR_BITS-1:0] cm_addr;
    logic [3:0]                     cm_lane_n;
    logic [sram_pkg::DATA_BITS-1:0] cm_data;

    assign cm_addr   = fifo_out_data[FW-1 -: sram_pkg::ADDR_BITS];
    assign cm_lane_n = fifo_out_data[sram_pkg::DATA_BITS +: 4];
    assign cm_data   = fifo_out_data[sram_pkg::DATA_BITS-1:0];

    // one storage array per lane, so every lane's writes have a single owning process
    genvar g;
    generate
        for (g = 0; g < sram_pkg::LANES; g++) begin : g_lane
            logic [sram_pkg::LANE_BITS-1:0] lane_mem_reg [sram_pkg::DEPTH];

            always_ff @(posedge mclk) begin
                if (fifo_out_valid && commit_en && !cm_lane_n[g]) begin
                    lane_mem_reg[cm_addr]
                        <= cm_data[g*sram_pkg::LANE_BITS +: sram_pkg::LANE_BITS];
                end
            end

            assign array_word[g*sram_pkg::LANE_BITS +: sram_pkg::LANE_BITS]
                = lane_mem_reg[cur_addr];
        end
    endgenerate

    // ************************************************
    // read path
    // ************************************************
    logic                           rd_vld_reg;
    logic [sram_pkg::DATA_BITS-1:0] rd_data_reg;
    logic                           out_vld_reg;
    logic [sram_pkg::DATA_BITS-1:0] out_data_reg;

    // reads see the array only; a read of a write still in flight gets old data
    always_ff @(posedge mclk) begin
        if (reset) begin
            rd_vld_reg  <= 1'b0;
            out_vld_reg <= 1'b0;
        end else if (adv_en) begin
            rd_vld_reg  <= do_read;
            out_vld_reg <= rd_vld_reg;
        end
    end

    always_ff @(posedge mclk) begin
        if (adv_en) begin
            rd_data_reg  <= array_word;
            out_data_reg <= rd_data_reg;
        end
    end

    // ************************************************
    // output drivers
    // ************************************************
    logic drive_next;

    assign drive_next = (mode_select_pin ? out_vld_reg : rd_vld_reg) && !oe_n_reg
                        && (pwr_reg == sram_pkg::SRAM_PWR_AWAKE);

    always_ff @(posedge mclk) begin
        if (reset) begin
            dq_oe  <= 1'b0;
            dq_out <= '0;
        end else begin
            dq_oe  <= drive_next && output_enable_n == 1'b0;
            dq_out <= mode_select_pin ? out_data_reg : rd_data_reg;
        end
    end

endmodule

// file: sram_port_sva.sv
/* pin-level assertions for sram_port
   assumes one mclk domain and a synchronous active-high reset */
`timescale 1ns/1ps
module sram_port_sva (
    input wire logic                          mclk,
    input wire logic                          reset,
    input wire logic                          clock_gate_n,
    input wire logic                          advance_load,
    input wire logic                          write_n,
    input wire logic                          chip_sel_one_n,
    input wire logic                          chip_sel_two,
    input wire logic                          chip_sel_three_n,
    input wire logic                          mode_select_pin,
    input wire logic                          output_enable_n,
    input wire logic                          sleep_request,
    input wire logic [sram_pkg::DATA_BITS-1:0] dq_out,
    input wire logic                          dq_oe,
    input wire logic                          sleeping,
    input wire logic                          write_stall
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    logic       act;
    logic       rd_load;
    logic [2:0] quiet_reg;
    logic [2:0] oe_cnt_reg;
    assign act = !clock_gate_n && !sleeping && !write_stall;
    assign rd_load = !chip_sel_one_n && chip_sel_two && !chip_sel_three_n && write_n
                     && !advance_load;
    // quiet counts active edges without a read or burst step; oe counter covers the sync
    always_ff @(posedge mclk) begin
        if (reset) begin
            quiet_reg  <= 3'h0;
            oe_cnt_reg <= 3'h0;
        end else begin
            if (output_enable_n) oe_cnt_reg <= 3'h0;
            else if (oe_cnt_reg != 3'h7) oe_cnt_reg <= oe_cnt_reg + 3'h1;
            if (act && (advance_load || rd_load)) quiet_reg <= 3'h0;
            else if (act && quiet_reg != 3'h7) quiet_reg <= quiet_reg + 3'h1;
        end
    end
    // ****
    // properties
    // ****
    sequence s_rd_taken;
        act && rd_load && !output_enable_n && oe_cnt_reg >= 3'h5;
    endsequence
    sequence s_live;
        act && !output_enable_n;
    endsequence
    a_reset_clears_out: assert property ($fell(reset) |-> !dq_oe && !sleeping && dq_out == '0)
        else $error("outputs not cleared by reset");
    a_pipe_read_drive: assert property (mode_select_pin ##0 s_rd_taken ##1 s_live [*2] |=> dq_oe)
        else $error("pipelined read not driven on time");
    a_flow_read_drive: assert property (!mode_select_pin ##0 s_rd_taken ##1 s_live |=> dq_oe)
        else $error("flow-through read not driven on time");
    a_idle_no_drive: assert property (quiet_reg >= 3'h4 |-> !dq_oe)
        else $error("data driven without a read");
    a_oe_forces_off: assert property (output_enable_n |=> !dq_oe)
        else $error("drivers on while output enable is off");
    a_sleep_entry_seen: assert property (sleep_request [*7] |-> sleeping)
        else $error("sleep request not honoured");
    a_sleep_exit_seen: assert property (!sleep_request [*7] |-> !sleeping)
        else $error("still asleep without a request");
    a_gate_freezes_data: assert property (clock_gate_n [*2] |=> $stable(dq_out))
        else $error("read data moved while clock gated");
endmodule
bind sram_port sram_port_sva u_sva (.*);

// file: sram_host_model.sv
/* host controller model: random bus traffic with late write data
   assumes the device samples on rising mclk; run low gives only deselects */
`timescale 1ns/1ps
module sram_host_model (
    input  wire logic                           mclk,
    input  wire logic                           reset,
    input  wire logic                           run,
    input  wire logic                           mode_select_pin,
    input  wire logic                           sleeping,
    input  wire logic                           write_stall,
    output logic                                clock_gate_n,
    output logic [sram_pkg::ADDR_BITS-1:0]      addr,
    output logic                                burst_seed_bit0,
    output logic                                burst_seed_bit1,
    output logic                                advance_load,
    output logic                                write_n,
    output logic [3:0]                          lane_n,
    output logic                                chip_sel_one_n,
    output logic                                chip_sel_two,
    output logic                                chip_sel_three_n,
    output logic [sram_pkg::DATA_BITS-1:0]      dq_in
);
    logic                           wr_live;
    logic [1:0]                     dv;
    logic [sram_pkg::DATA_BITS-1:0] dd [2];
    initial begin
        {clock_gate_n, addr, burst_seed_bit0, burst_seed_bit1, advance_load, write_n} = '0;
        {lane_n, chip_sel_one_n, chip_sel_two, chip_sel_three_n, dq_in} = '1;
        wr_live = 1'b0;
        dv = 2'h0;
    end
    // slot 0 holds the data due at the next active edge; gated edges hold it
    always @(posedge mclk) begin
        logic        act;
        logic [31:0] r;
        logic [63:0] w;
        act = !clock_gate_n && !sleeping && !write_stall;
        r = $urandom;
        w = {$urandom, $urandom};
        if (reset) begin
            dv = 2'h0;
            wr_live = 1'b0;
        end else if (act) begin
            if (!advance_load)
                wr_live = !chip_sel_one_n && chip_sel_two && !chip_sel_three_n && !write_n;
            dv = {1'b0, dv[1]};
            dd[0] = dd[1];
            if (wr_live) begin
                dv[mode_select_pin] = 1'b1;
                dd[mode_select_pin] = w[sram_pkg::DATA_BITS-1:0];
            end
        end
        clock_gate_n     <= run && r[28:26] == 3'h0;
        advance_load     <= run && r[1:0] == 2'h3;
        write_n          <= r[2];
        lane_n           <= r[3] ? 4'h0 : r[7:4];
        chip_sel_one_n   <= !run || r[10:8] == 3'h0;
        chip_sel_two     <= r[13:11] != 3'h0;
        chip_sel_three_n <= r[16:14] == 3'h0;
        addr             <= {r[29], r[29], r[22:17]};
        burst_seed_bit0  <= r[23];
        burst_seed_bit1  <= r[24];
        dq_in            <= dv[0] ? dd[0] : ~dq_in;
    end
endmodule

// file: sram_port_tb.sv
/* self-checking bench for sram_port: random host traffic and a scoreboard
   assumes the host model and the checker are compiled before this file */
`timescale 1ns/1ps
module sram_port_tb;
    typedef logic [sram_pkg::DATA_BITS-1:0] sram_word_t;
    logic mclk, reset, run, mode_select_pin, burst_order_select, output_enable_n;
    logic sleep_request, clock_gate_n, burst_seed_bit0, burst_seed_bit1, advance_load;
    logic write_n, chip_sel_one_n, chip_sel_two, chip_sel_three_n, dq_oe, sleeping;
    logic write_stall, lane_a_write_n, lane_b_write_n, lane_c_write_n, lane_d_write_n;
    logic [3:0]                     lane_n;
    logic [sram_pkg::ADDR_BITS-1:0] addr, base;
    sram_word_t                     dq_in, dq_out, rd [3];
    sram_word_t                     mem [sram_pkg::DEPTH];
    logic [3:0]                     mem_v [sram_pkg::DEPTH], wl [2];
    int                             wr_at [sram_pkg::DEPTH];
    logic [7:0]                     wa [2];
    logic [2:0]                     rv, rk;
    logic [1:0]                     wv, seed, beat;
    logic                           live, live_rd, prev_act;
    int                             ecnt = 0;
    int                             oe_cnt, n_mismatch, compares;
    assign {lane_d_write_n, lane_c_write_n, lane_b_write_n, lane_a_write_n} = lane_n;
    sram_port u_sram_port (.*);
    sram_host_model u_sram_host_model (.*);
    task automatic check(input string what, input sram_word_t seen, input sram_word_t exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    function automatic logic [7:0] beat_addr(logic [7:0] b, logic [1:0] s, logic [1:0] n,
                                             logic lo);
        return {b[7:2], lo ? s ^ n : s + n};
    endfunction
    // ****
    // scoreboard: read slots mature one edge after the output register loads
    // ****
    always @(posedge mclk) begin
        logic       act;
        logic       sel;
        logic       op;
        logic [7:0] a;
        int         lat;
        act = !clock_gate_n && !sleeping && !write_stall;
        sel = !chip_sel_one_n && chip_sel_two && !chip_sel_three_n;
        lat = mode_select_pin ? 2 : 1;
        if (reset) begin
            rv = 3'h0;
            wv = 2'h0;
            live = 1'b0;
            prev_act = 1'b0;
            oe_cnt = 0;
            foreach (mem_v[i]) mem_v[i] = 4'h0;
        end else begin
            ecnt++;
            // the enable synchroniser is loosely timed, so its first edges go unchecked
            if (act && prev_act && (oe_cnt == 0 || oe_cnt > 4)) begin
                check("dq_oe", sram_word_t'(dq_oe), sram_word_t'(rv[0] && oe_cnt > 4));
                if (rv[0] && rk[0] && oe_cnt > 4) check("dq_out", dq_out, rd[0]);
            end
            if (act) begin
                if (wv[0]) begin
                    for (int i = 0; i < 4; i++)
                        if (!wl[0][i]) begin
                            mem[wa[0]][i*9 +: 9] = dq_in[i*9 +: 9];
                            mem_v[wa[0]][i] = 1'b1;
                        end
                    wr_at[wa[0]] = ecnt;
                end
                rv = rv >> 1;
                rk = rk >> 1;
                rd = '{rd[1], rd[2], rd[2]};
                wv = wv >> 1;
                wa = '{wa[1], wa[1]};
                wl = '{wl[1], wl[1]};
                op = 1'b0;
                if (!advance_load) begin
                    live = sel;
                    live_rd = write_n;
                    base = addr;
                    seed = {burst_seed_bit1, burst_seed_bit0};
                    beat = 2'h0;
                    op = sel;
                end else if (live) begin
                    beat++;
                    op = 1'b1;
                end
                a = beat_addr(base, seed, beat, burst_order_select);
                if (op && live_rd) begin
                    rv[lat] = 1'b1;
                    rd[lat] = mem[a];
                    rk[lat] = &mem_v[a] && ecnt - wr_at[a] > 4;
                end
                if (op && !live_rd) begin
                    wv[lat-1] = 1'b1;
                    wa[lat-1] = a;
                    wl[lat-1] = lane_n;
                end
            end
            prev_act = act;
            oe_cnt = output_enable_n ? 0 : oe_cnt + 1;
        end
    end
    task automatic wait_sleep(input logic lvl);
        int k;
        k = 0;
        while (sleeping !== lvl && k < 12) begin
            @(negedge mclk);
            k++;
        end
        check("sleeping", sram_word_t'(sleeping), sram_word_t'(lvl));
        if (k == 12) finish_test();
    endtask
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial begin
        {reset, run, mode_select_pin, burst_order_select, sleep_request} = 5'h10;
        output_enable_n = 1'b1;
        n_mismatch = 0;
        compares = 0;
        void'($urandom(14219));
        for (int s = 0; s < 4; s++) begin
            @(posedge mclk);
            reset <= 1'b1;
            mode_select_pin <= s[0];
            burst_order_select <= s[1];
            repeat (8) @(posedge mclk);
            reset <= 1'b0;
            output_enable_n <= 1'b0;
            @(negedge mclk);
            check("reset flags", sram_word_t'({dq_oe, sleeping, write_stall}), '0);
            check("reset data", dq_out, '0);
            @(posedge mclk);
            run <= 1'b1;
            repeat (700) @(posedge mclk);
            output_enable_n <= 1'b1;
            repeat (40) @(posedge mclk);
            output_enable_n <= 1'b0;
            repeat (200) @(posedge mclk);
            run <= 1'b0;
            repeat (10) @(posedge mclk);
            sleep_request <= 1'b1;
            wait_sleep(1'b1);
            @(posedge mclk);
            run <= 1'b1;
            repeat (20) begin
                @(negedge mclk);
                check("asleep dq_oe", sram_word_t'(dq_oe), '0);
            end
            @(posedge mclk);
            run <= 1'b0;
            sleep_request <= 1'b0;
            wait_sleep(1'b0);
        end
        finish_test();
    end
endmodule
